/* shared/cbs_pkg.sv */
// Purpose: shared constants and carriers for the configuration burst source
// Assumes: ref_clk at 125 MHz; link clock sampled as an ordinary input
// Notes: memory depth is a module parameter of the top; data and address widths are fixed here
package cbs_pkg;
    localparam int CBS_DATA_W = 16;
    localparam int CBS_ADDR_W = 23;
    localparam int CBS_CLK_MHZ = 125;
    // settle time after reset before the ready line is released, in ns
    localparam int CBS_READY_DELAY_NS = 1000;
    localparam int CBS_READY_DELAY_CYC =
        (CBS_READY_DELAY_NS * CBS_CLK_MHZ + 999) / 1000;
    // synthetic program/erase busy time, in ns
    localparam int CBS_PROG_TIME_NS = 2000;
    localparam int CBS_PROG_TIME_CYC = (CBS_PROG_TIME_NS * CBS_CLK_MHZ) / 1000;
    localparam logic [1:0] CBS_SYNC_ONES = 2'h3;
    localparam logic [1:0] CBS_SYNC_ZEROS = 2'h0;

    typedef enum logic [1:0] {
        CBS_ST_RESET = 2'h0,
        CBS_ST_WAIT_HIGH = 2'h1,
        CBS_ST_LATCH = 2'h2,
        CBS_ST_BURST = 2'h3
    } cbs_state_type;

    // program/erase request from the user side
    typedef struct packed {
        logic start;
        logic erase;
        logic [CBS_ADDR_W-1:0] addr;
        logic [CBS_DATA_W-1:0] data;
    } cbs_prog_req_type;

    // open-drain handshake line as two signals
    typedef struct packed {
        logic out;
        logic oe;
    } cbs_od_type;
endpackage : cbs_pkg

/* verilog/cbs_sync3.sv */
// Purpose: three flop synchroniser with agreement filter for one pin
// Assumes: pin is asynchronous to ref_clk
// Notes: the first flop feeds only the second; a change counts when the
//        second and third agree
`timescale 1ns/1ps
module cbs_sync3 #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic pin,
    output logic level
);
    logic stage1;
    logic stage2;
    logic stage3;

    // -----------------------------------------------------------------
    // synchroniser chain
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
            level <= RESET_VALUE;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3; // filter single-cycle disagreement
            end
        end
    end
endmodule : cbs_sync3

/* verilog/cbs_burst_source.sv */
// Purpose: flash side of the power-on configuration handshake and burst read
// Assumes: link clock, latch strobe, address, supply control are async pins
// Notes: memory contents only change through the program/erase port
//
// Contract
// RULE1: supply control below lockout refuses program/erase; in range permits.
// RULE2: supply control sampled only at operation start; later changes ignored.
// RULE3: drive the ready line low throughout the reset period.
// RULE4: both parties release the open-drain ready line once internally ready.
// RULE5: board pull-up raises the wired line, marking configuration start.
// RULE6: partner samples its mode inputs at configuration start.
// RULE7: partner or board resistors present the start read address.
// RULE8: load presented start address into counter, present first 16-bit word.
// RULE9: each following link clock period: increment counter, output next word.
// RULE10: 16-bit parallel bus, one word per period, no wait states.
// RULE11: external link clock must not exceed the maximum burst frequency.
// RULE12: partner must not rely on fallback images in slave mode.
// RULE13: partner signals completion on its done output.
// RULE14: after reset, wait for the line seen high before reads or commands.
// RULE15: outside agent may pull the line low to restart; supplies new address.
// RULE16: latch strobe held high through power-up and the first latch sequence.
// RULE17: capture address on the configured clock edge while strobe is low.
`timescale 1ns/1ps
module cbs_burst_source
    import cbs_pkg::*;
#(
    parameter int MEM_DEPTH = 1024,
    parameter int READY_DELAY = cbs_pkg::CBS_READY_DELAY_CYC,
    parameter int PROG_TIME = cbs_pkg::CBS_PROG_TIME_CYC,
    parameter logic FALLING_EDGE = 1'b0
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cfg_transfer_clock,
    input wire logic latch_n,
    input wire logic [cbs_pkg::CBS_ADDR_W-1:0] addr_in,
    input wire logic ready_line_in,
    output logic ready_line_out,
    output logic ready_line_oe,
    output logic [cbs_pkg::CBS_DATA_W-1:0] data_out,
    output logic data_valid,
    input wire logic program_control_range,
    input wire cbs_pkg::cbs_prog_req_type prog_req,
    output logic prog_busy,
    output logic prog_refused,
    output logic line_ready
);
    import cbs_pkg::*;

    localparam int IDX_W = $clog2(MEM_DEPTH);
    localparam int DLY_W = $clog2(READY_DELAY + 1) + 1;
    localparam int PRG_W = $clog2(PROG_TIME + 1) + 1;

    // refuse depths the wrapping index cannot serve and empty timers
    if (MEM_DEPTH < 2 || MEM_DEPTH != (1 << IDX_W) || IDX_W > CBS_ADDR_W
        || READY_DELAY < 1 || PROG_TIME < 1) begin : g_bad_param
        $error("cbs_burst_source: bad parameter");
    end

    logic [CBS_DATA_W-1:0] mem [MEM_DEPTH];
    cbs_state_type state;
    cbs_state_type next_state;
    logic [DLY_W-1:0] delay_count;
    logic [PRG_W-1:0] prog_count;
    logic [CBS_ADDR_W-1:0] addr_count;
    logic clk_s;
    logic clk_prev;
    logic latch_s;
    logic line_s;
    logic supply_ok_s;
    logic [CBS_ADDR_W-1:0] addr_s;

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    cbs_sync3 #(.RESET_VALUE(1'b0)) u_clk_sync (
        .ref_clk(ref_clk), .reset(reset), .pin(cfg_transfer_clock), .level(clk_s)
    );
    cbs_sync3 #(.RESET_VALUE(1'b1)) u_latch_sync (
        .ref_clk(ref_clk), .reset(reset), .pin(latch_n), .level(latch_s)
    );
    cbs_sync3 #(.RESET_VALUE(1'b0)) u_line_sync (
        .ref_clk(ref_clk), .reset(reset), .pin(ready_line_in), .level(line_s)
    );
    cbs_sync3 #(.RESET_VALUE(1'b0)) u_supply_sync (
        .ref_clk(ref_clk), .reset(reset), .pin(program_control_range),
        .level(supply_ok_s)
    );

    // the address bus is quasi-static while the strobe is low, so per-bit
    // skew through these chains settles long before the capturing edge
    for (genvar i = 0; i < CBS_ADDR_W; i++) begin : g_addr_sync
        cbs_sync3 #(.RESET_VALUE(1'b0)) u_addr_sync (
            .ref_clk(ref_clk), .reset(reset), .pin(addr_in[i]), .level(addr_s[i])
        );
    end

    // -----------------------------------------------------------------
    // link clock edge detection and decode
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= clk_s;
        end
    end

    wire rise_edge = clk_s & ~clk_prev;
    wire fall_edge = ~clk_s & clk_prev;
    wire active_edge = FALLING_EDGE ? fall_edge : rise_edge;
    wire delay_done = (delay_count == DLY_W'(READY_DELAY));
    wire line_low = ~line_s;
    wire [IDX_W-1:0] rd_idx = addr_count[IDX_W-1:0];
    wire [IDX_W-1:0] next_idx = IDX_W'(addr_count + 1'b1);
    wire [IDX_W-1:0] latch_idx = addr_s[IDX_W-1:0];
    wire prog_start = prog_req.start & (state != CBS_ST_RESET)
                      & (state != CBS_ST_WAIT_HIGH) & ~prog_busy;
    wire prog_accept = prog_start & supply_ok_s; // see RULE1
    wire prog_done = prog_busy & (prog_count == PRG_W'(PROG_TIME));

    // -----------------------------------------------------------------
    // handshake and burst state machine
    // -----------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            CBS_ST_RESET: begin
                if (delay_done) begin
                    next_state = CBS_ST_WAIT_HIGH; // see RULE4
                end
            end
            CBS_ST_WAIT_HIGH: begin
                if (line_s) begin
                    next_state = CBS_ST_LATCH; // see RULE14
                end
            end
            CBS_ST_LATCH: begin
                if (line_low) begin
                    next_state = CBS_ST_WAIT_HIGH;
                end else if (active_edge && !latch_s) begin
                    next_state = CBS_ST_BURST; // see RULE17
                end
            end
            CBS_ST_BURST: begin
                if (line_low) begin
                    next_state = CBS_ST_WAIT_HIGH; // restart needs a new address
                end
            end
            default: begin
                next_state = CBS_ST_RESET;
            end
        endcase
    end

    // state, delay counter and open-drain drive
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= CBS_ST_RESET;
            delay_count <= '0;
            ready_line_out <= 1'b0;
            ready_line_oe <= 1'b1; // see RULE3
            line_ready <= 1'b0;
        end else begin
            state <= next_state;
            if (state == CBS_ST_RESET && !delay_done) begin
                delay_count <= DLY_W'(delay_count + 1'b1);
            end
            ready_line_out <= 1'b0;
            ready_line_oe <= (next_state == CBS_ST_RESET); // see RULE3
            line_ready <= (next_state == CBS_ST_LATCH) || (next_state == CBS_ST_BURST);
        end
    end

    // -----------------------------------------------------------------
    // address counter and data path
    // -----------------------------------------------------------------
    // the word leaves on the same ref_clk edge as the counter moves, so one
    // word per link period with no wait states
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            addr_count <= '0;
            data_out <= '0;
            data_valid <= 1'b0;
        end else if (state == CBS_ST_LATCH && next_state == CBS_ST_BURST) begin
            addr_count <= addr_s; // see RULE8
            data_out <= mem[latch_idx]; // see RULE8
            data_valid <= 1'b1;
        end else if (state == CBS_ST_BURST && next_state == CBS_ST_BURST
                     && active_edge) begin
            addr_count <= CBS_ADDR_W'(addr_count + 1'b1); // see RULE9
            data_out <= mem[next_idx]; // see RULE9, see RULE10
        end else if (next_state != CBS_ST_BURST) begin
            data_valid <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // program and erase
    // -----------------------------------------------------------------
    // the supply level is looked at only in the start cycle; once busy the
    // operation runs to its end whatever the pin does
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prog_busy <= 1'b0;
            prog_refused <= 1'b0;
            prog_count <= '0;
        end else begin
            prog_refused <= prog_start & ~supply_ok_s; // see RULE1
            if (prog_accept) begin
                prog_busy <= 1'b1; // see RULE2
                prog_count <= '0;
            end else if (prog_done) begin
                prog_busy <= 1'b0;
            end else if (prog_busy) begin
                prog_count <= PRG_W'(prog_count + 1'b1); // see RULE2
            end
        end
    end

    // memory write; no reset so it maps to a RAM
    always_ff @(posedge ref_clk) begin
        if (prog_accept) begin
            mem[prog_req.addr[IDX_W-1:0]] <= prog_req.erase ? {CBS_DATA_W{1'b1}}
                                                            : prog_req.data;
        end
    end
endmodule : cbs_burst_source

/* tb/cbs_burst_source_sva.sv */
// Purpose: port checker for the burst source
// Assumes: PROG_TIME of 8, supply pin steady five cycles before a start
// Notes: attached to every instance of the top by the bind below
`timescale 1ns/1ps
module cbs_burst_source_sva
    import cbs_pkg::*;
#(
    parameter int READY_DELAY = 2
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ready_line_in,
    input wire logic ready_line_out,
    input wire logic ready_line_oe,
    input wire logic [cbs_pkg::CBS_DATA_W-1:0] data_out,
    input wire logic data_valid,
    input wire logic program_control_range,
    input wire cbs_pkg::cbs_prog_req_type prog_req,
    input wire logic prog_busy,
    input wire logic prog_refused,
    input wire logic line_ready
);
    import cbs_pkg::*;
    localparam int REL_MAX = READY_DELAY + 3;
    // a start that the block is free to take
    wire go = prog_req.start && line_ready && !prog_busy;
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    a_reset_pulls_low: assert property (reset |=> ready_line_oe && !ready_line_out)
        else $error("ready line not pulled low in reset");
    a_release_bound: assert property ($fell(reset) |-> ##[0:REL_MAX] !ready_line_oe)
        else $error("ready line never released");
    a_stays_released: assert property (disable iff (reset) !ready_line_oe |=> !ready_line_oe)
        else $error("ready line pulled again without reset");
    a_oe_blocks_ready: assert property (disable iff (reset) ready_line_oe |-> !line_ready)
        else $error("ready while still pulling line low");
    a_low_line_drops: assert property (disable iff (reset) (!ready_line_in)[*8] |-> !line_ready)
        else $error("still ready with line held low");
    a_valid_needs_ready: assert property (disable iff (reset) data_valid |-> line_ready)
        else $error("burst data before line seen high");
    a_refuse_lockout: assert property (disable iff (reset)
        (!program_control_range)[*5] ##0 go |=> prog_refused && !prog_busy)
        else $error("operation not refused in lockout");
    a_permit_range: assert property (disable iff (reset)
        program_control_range[*5] ##0 go |=> prog_busy && !prog_refused)
        else $error("operation not started in control range");
    a_busy_span: assert property (disable iff (reset)
        $rose(prog_busy) |-> prog_busy[*8] ##1 prog_busy ##1 !prog_busy)
        else $error("program time not kept");
    a_word_stands: assert property (disable iff (reset)
        $changed(data_out) |=> ($stable(data_out))[*8])
        else $error("word changed within one link period");
    c_refused: cover property (go ##1 prog_refused);
    c_burst: cover property ($rose(data_valid));
    c_restart: cover property ($fell(line_ready));
endmodule : cbs_burst_source_sva

bind cbs_burst_source cbs_burst_source_sva #(.READY_DELAY(READY_DELAY)) chk (
    .ref_clk(ref_clk), .reset(reset), .ready_line_in(ready_line_in),
    .ready_line_out(ready_line_out), .ready_line_oe(ready_line_oe), .data_out(data_out),
    .data_valid(data_valid), .program_control_range(program_control_range),
    .prog_req(prog_req), .prog_busy(prog_busy), .prog_refused(prog_refused),
    .line_ready(line_ready));

/* tb/cbs_fpga_model.sv */
// Purpose: configuration side: init pull, link clock, start address
// Assumes: slave mode, start address given per frame, no fallback image
// Notes: link clock idles low between frames; address inverts after capture
`timescale 1ns/1ps
module cbs_fpga_model
    import cbs_pkg::*;
(
    input wire logic dev_oe,
    output logic line,
    output logic link_clk,
    output logic latch_n,
    output logic [cbs_pkg::CBS_ADDR_W-1:0] addr
);
    import cbs_pkg::*;
    logic hold_low = 1'b0;
    logic done = 1'b0;
    // wired line: the board pull-up wins only when nobody pulls low
    assign line = !(dev_oe || hold_low);
    // strobe high from power-up, clock still outside frames
    initial begin
        link_clk = 1'b0;
        latch_n = 1'b1;
        addr = '0;
    end
    // one 160 ns period, far below the burst limit
    task automatic tick();
        #80 link_clk = 1'b1;
        #80 link_clk = 1'b0;
    endtask : tick
    // frame start with the address the caller gives, held only through the strobe-low period and inverted afterwards
    task automatic start_read(input logic [CBS_ADDR_W-1:0] a);
        #3 addr = a;
        latch_n = 1'b0;
        tick();
        latch_n = 1'b1;
        addr = ~a;
    endtask : start_read
    // configuration over: the partner raises its internal done flag
    task automatic finish();
        done = 1'b1;
    endtask : finish
    // restart by pulling the shared line low
    task automatic pull(input logic v);
        hold_low = v;
    endtask : pull
endmodule : cbs_fpga_model

/* tb/cbs_burst_source_tb.sv */
// Purpose: self-checking bench for the burst source
// Assumes: settle and program times shortened to 2 and 8 cycles
// Notes: the partner model times the link clock with its own 80 ns delays, not the reference edges
`timescale 1ns/1ps
module cbs_burst_source_tb;
    import cbs_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic supply_ok = 1'b1;
    cbs_prog_req_type req = '0;
    logic line, oe, rlo, lclk, latch_n, busy, refused, rdy, valid;
    logic [CBS_ADDR_W-1:0] addr;
    logic [CBS_DATA_W-1:0] dout;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    int span;
    always #4 ref_clk = ~ref_clk;
    cbs_fpga_model fpga (.dev_oe(oe), .line(line), .link_clk(lclk), .latch_n(latch_n),
        .addr(addr));
    cbs_burst_source #(.READY_DELAY(2), .PROG_TIME(8)) dut (.ref_clk(ref_clk),
        .reset(reset), .cfg_transfer_clock(lclk), .latch_n(latch_n), .addr_in(addr),
        .ready_line_in(line), .ready_line_out(rlo), .ready_line_oe(oe), .data_out(dout),
        .data_valid(valid), .program_control_range(supply_ok), .prog_req(req),
        .prog_busy(busy), .prog_refused(refused), .line_ready(rdy));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    // one start pulse; answer is visible just after the taking edge
    task automatic prog(input logic er, input logic [CBS_ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        req <= '{1'b1, er, a, d};
        @(posedge ref_clk);
        req.start <= 1'b0;
        #1;
    endtask : prog
    // bounded wait for busy to fall, counting the edges at which it stood;
    // busy is read 1 ns after each edge so it has settled
    task automatic wait_idle();
        for (span = 0; span < 40 && busy !== 1'b0; span++) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : wait_idle
    task automatic supply(input logic v);
        @(posedge ref_clk);
        supply_ok <= v;
        repeat (6) @(posedge ref_clk);
    endtask : supply
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        repeat (7) @(posedge ref_clk);
        #1 check({14'h0, oe, rlo}, 16'h2, "pull low in reset");
        @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 40 && rdy !== 1'b1; i++) @(posedge ref_clk);
        #1 check({14'h0, oe, rdy}, 16'h1, "release and ready");
        $display("done: reset");
    endtask : t_reset
    task automatic t_prog();
        prog(1'b0, 23'h5, 16'h1234);
        check({15'h0, busy}, 16'h1, "busy in range");
        wait_idle();
        check(16'(span), 16'h9, "busy span");
        prog(1'b0, 23'h6, 16'habcd);
        // drop the supply early enough to reach the synchroniser while busy
        fork
            wait_idle();
            begin
                @(posedge ref_clk);
                supply_ok <= 1'b0;
            end
        join
        check(16'(span), 16'h9, "span with supply dropped");
        supply(1'b0);
        prog(1'b0, 23'h6, 16'h5555);
        check({14'h0, busy, refused}, 16'h1, "lockout refusal");
        supply(1'b1);
        prog(1'b1, 23'h7, 16'h0);
        wait_idle();
        $display("done: program");
    endtask : t_prog
    task automatic t_burst();
        fpga.start_read(23'h5);
        check(dout, 16'h1234, "first word");
        check({15'h0, valid}, 16'h1, "valid");
        fpga.tick();
        check(dout, 16'habcd, "second word");
        fpga.tick();
        check(dout, 16'hffff, "erased word");
        fpga.finish();
        $display("done: burst");
    endtask : t_burst
    task automatic t_restart();
        fpga.pull(1'b1);
        repeat (10) @(posedge ref_clk);
        #1 check({14'h0, rdy, valid}, 16'h0, "line low");
        fpga.pull(1'b0);
        for (int i = 0; i < 40 && rdy !== 1'b1; i++) @(posedge ref_clk);
        fpga.start_read(23'h6);
        check(dout, 16'habcd, "restart word");
        $display("done: restart");
    endtask : t_restart
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    // cut a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            $display("[FAIL] %0t timeout", $time);
            give_verdict();
        end
    end
    initial begin
        t_reset();
        t_prog();
        t_burst();
        t_restart();
        give_verdict();
    end
endmodule : cbs_burst_source_tb
